// ---- spih_pkg.sv ----
// spih_pkg: constants shared by the serial control port ends.
// assumes both ends run on one 20 MHz clock and import this package whole.
package spih_pkg;

  // ---------------------------------------------------------------
  // instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0] INS_WRITE    = 8'h02;
  localparam logic [7:0] INS_READ     = 8'h03;
  localparam logic [7:0] INS_BUF_READ = 8'h04;

  // ---------------------------------------------------------------
  // register map and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_TRACE_ADDR = 8'h00;
  localparam logic [7:0] ADDR_TRACE_DATA = 8'h01;
  localparam logic [7:0] ADDR_MODE_ONE   = 8'h03;
  localparam logic [7:0] ADDR_FLAGS      = 8'h04;
  localparam logic [7:0] ADDR_SUPPRESS   = 8'h05;
  localparam logic [7:0] FLAGS_RESET     = 8'hFF;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SEL_RUN_BIT  = 0;
  localparam int SEL_IRQ_BIT  = 1;
  localparam int SEL_CLK_BIT  = 2;
  localparam int IRQ_POL_BIT  = 5;
  localparam int F_WAKE_A     = 0;
  localparam int F_LOCK_A     = 1;
  localparam int F_ID_A       = 2;
  localparam int F_END_A      = 3;
  localparam int F_WAKE_B     = 4;
  localparam int F_LOCK_B     = 5;
  localparam int F_ID_B       = 6;
  localparam int F_END_B      = 7;
  localparam int STAT_OVF_BIT = 7;
  localparam int STAT_CNT_W   = 6;

  // ---------------------------------------------------------------
  // sizes and timing
  // ---------------------------------------------------------------
  localparam int BYTE_BITS    = 8;
  localparam int BUF_BITS_DEF = 32;
  localparam int HOST_HALF_NS = 400;
  localparam int CLK_PERIOD_NS = 50;
  localparam int HOST_HALF_DEF = HOST_HALF_NS / CLK_PERIOD_NS;
  localparam logic [2:0] DEV_PIN_IDLE   = 3'h4;
  localparam logic [0:0] HOST_MISO_IDLE = 1'h0;

  typedef enum logic [1:0] {
    OP_WRITE = 2'b00,
    OP_READ  = 2'b01,
    OP_BUF   = 2'b10
  } spih_op_e;

endpackage : spih_pkg

// ---- spih_if.sv ----
// spih_if: serial link and shared output pins between host and device.
// assumes a testbench joins the two ends; miso_oe tells when miso is driven.
`timescale 1ns/100ps
interface spih_if;
  logic chip_select_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic irq_pin;
  logic clk_data_pin;
  logic run_pin;

  modport device (
    input  chip_select_n,
    input  sck,
    input  mosi,
    output miso,
    output miso_oe,
    output irq_pin,
    output clk_data_pin,
    output run_pin
  );

  modport host (
    output chip_select_n,
    output sck,
    output mosi,
    input  miso,
    input  miso_oe,
    input  irq_pin,
    input  clk_data_pin,
    input  run_pin
  );
endinterface : spih_if

// ---- spih_sync.sv ----
// spih_sync: two-flop synchroniser for pins from the other party.
// assumes the inputs are levels; the first stage feeds only the second.
`timescale 1ns/100ps
module spih_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= RST;
      dout   <= RST;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : spih_sync

// ---- spih_device.sv ----
// spih_device: serial control port slave plus interrupt unit of the receiver.
// assumes events and pin sources come from logic on clk; link pins are synchronised.
//
// Notes on behaviour
// - three mode bits route three shared pins
// - irq select bit: interrupt or data strobe
// - polarity bit five inverts interrupt to high
// - events set flags; unsuppressed flags raise interrupt
// - reset event sets all flags, pin low
// - first event after reset clears all, releases
// - wakeup clears frame locks and other wakeup
// - frame lock clears ends, ids, other lock
// - reading flags clears them after shifting out
// - reset indication interrupt cannot be suppressed
// - locked buffer message end holds interrupt
// - flag order: B end,id,lock,wake then A
// - suppress bit one masks matching flag
// - sample on rising, shift on falling
// - master frames every operation with select low
// - many frames per select, new instruction switches
// - msb first except buffer in arrival order
// - read: instruction, address, then data out
// - write: instruction, address, data stored
// - writes copy address and data to traces
// - buffer read: bits then count status byte
// - decode codes 02 write, 03 read, 04 buffer
// - status: count low six, overflow bit seven
`timescale 1ns/100ps
module spih_device
  import spih_pkg::*;
#(
  parameter int BUF_W = BUF_BITS_DEF
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  spih_if.device                     link,
  input  wire logic [7:0]            events,
  input  wire logic                  reset_event,
  input  wire logic                  buffer_lock_enable,
  input  wire logic                  host_run_mode,
  input  wire logic [BUF_W-1:0]      buf_bits,
  input  wire logic [STAT_CNT_W-1:0] buf_count,
  input  wire logic                  buf_overflow,
  input  wire logic                  divided_clock_out,
  input  wire logic                  rx_data,
  input  wire logic                  rx_data_strobe,
  input  wire logic                  rx_running,
  output logic                       buf_read_done
);
  localparam int TW = BUF_W + BYTE_BITS;
  localparam int CW = $clog2(TW + 1);

  typedef enum logic [2:0] {
    ST_INSTR = 3'b000,
    ST_ADDR  = 3'b001,
    ST_WDATA = 3'b010,
    ST_RDATA = 3'b011,
    ST_BUF   = 3'b100,
    ST_SKIP  = 3'b101
  } spih_dst_e;

  typedef struct packed {
    spih_dst_e     st;
    logic [CW-1:0] cnt;
    logic [7:0]    sh;
    logic [7:0]    addr;
    logic          is_write;
    logic [TW-1:0] tx;
    logic          sck_prev;
    logic          miso;
    logic          miso_oe;
    logic [7:0]    mode_one;
    logic [7:0]    suppress;
    logic [7:0]    flags;
    logic [7:0]    during_read;
    logic          after_reset, lock_hold;
    logic [7:0]    trace_addr, trace_data;
    logic          irq_pin, clk_data_pin, run_pin, buf_done;
  } spih_dev_s;

  localparam spih_dev_s DEV_RST = '{st: ST_INSTR, flags: FLAGS_RESET, after_reset: 1'b1, default: '0};

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic cs_n_s, sck_s, mosi_s;

  spih_sync #(.W(3), .RST(DEV_PIN_IDLE)) u_sync (
    .clk(clk), .rst_n(rst_n), .din({link.chip_select_n, link.sck, link.mosi}), .dout({cs_n_s, sck_s, mosi_s})
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  spih_dev_s q;
  spih_dev_s d;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input spih_dev_s s);
    logic [7:0] v;
    v = REG_RESET;
    unique case (a)
      ADDR_TRACE_ADDR: v = s.trace_addr;
      ADDR_TRACE_DATA: v = s.trace_data;
      ADDR_FLAGS:      v = s.flags;
      default:         v = REG_RESET;
    endcase
    return v;
  endfunction : reg_read

  always_comb begin
    logic       rise, fall, byte_end, rd_clear, snap, active, level;
    logic [7:0] bit_in, clr, base;
    rise     = sck_s & ~q.sck_prev;
    fall     = ~sck_s & q.sck_prev;
    bit_in   = {q.sh[6:0], mosi_s};
    byte_end = (q.cnt == CW'(BYTE_BITS - 1));
    rd_clear = 1'b0;
    snap     = 1'b0;
    clr      = '0;
    base     = q.flags;
    active   = 1'b0;
    level    = 1'b1;
    d          = q;
    d.sck_prev = sck_s;
    d.miso_oe  = ~cs_n_s;
    d.buf_done = 1'b0;

    if (cs_n_s) begin
      d.st  = ST_INSTR;
      d.cnt = '0;
    end else if (rise) begin
      d.sh  = bit_in;
      d.cnt = q.cnt + CW'(1);
      unique case (q.st)
        ST_INSTR: if (byte_end) begin
          d.cnt = '0;
          unique case (bit_in)
            INS_WRITE, INS_READ: begin
              d.st       = ST_ADDR;
              d.is_write = (bit_in == INS_WRITE);
            end
            INS_BUF_READ: begin
              d.st = ST_BUF;
              d.tx = {buf_bits, buf_overflow, 1'b0, buf_count};
            end
            default: d.st = ST_SKIP;
          endcase
        end
        ST_ADDR: if (byte_end) begin
          d.cnt  = '0;
          d.addr = bit_in;
          if (q.is_write) begin
            d.st = ST_WDATA;
          end else begin
            d.st = ST_RDATA;
            d.tx = {reg_read(bit_in, q), {BUF_W{1'b0}}};
            snap = (bit_in == ADDR_FLAGS);
          end
        end
        ST_WDATA: if (byte_end) begin
          d.cnt = '0;
          d.st  = ST_INSTR;
          unique case (q.addr)
            ADDR_MODE_ONE: d.mode_one = bit_in;
            ADDR_SUPPRESS: d.suppress = bit_in;
            default: ;
          endcase
          d.trace_addr = q.addr;
          d.trace_data = bit_in;
        end
        ST_RDATA: if (byte_end) begin
          d.cnt    = '0;
          d.st     = ST_INSTR;
          rd_clear = (q.addr == ADDR_FLAGS);
        end
        ST_BUF: if (q.cnt == CW'(TW - 1)) begin
          d.cnt      = '0;
          d.st       = ST_INSTR;
          d.buf_done = 1'b1;
        end
        ST_SKIP: d.cnt = '0;
        default: d.st = ST_SKIP;
      endcase
    end else if (fall) begin
      d.miso = q.tx[TW-1];
      d.tx   = {q.tx[TW-2:0], 1'b0};
    end

    // ---------------------------------------------------------------
    // interrupt unit
    // ---------------------------------------------------------------
    // wakeup and frame lock side clears
    if (events[F_WAKE_A]) clr = clr | (8'h01 << F_LOCK_A) | (8'h01 << F_LOCK_B) | (8'h01 << F_WAKE_B);
    if (events[F_WAKE_B]) clr = clr | (8'h01 << F_LOCK_A) | (8'h01 << F_LOCK_B) | (8'h01 << F_WAKE_A);
    if (events[F_LOCK_A] | events[F_LOCK_B]) begin
      clr = clr | (8'h01 << F_END_A) | (8'h01 << F_END_B) | (8'h01 << F_ID_A) | (8'h01 << F_ID_B);
    end
    if (events[F_LOCK_A]) clr = clr | (8'h01 << F_LOCK_B);
    if (events[F_LOCK_B]) clr = clr | (8'h01 << F_LOCK_A);

    d.during_read = (snap ? REG_RESET : q.during_read) | events;
    base = rd_clear ? q.during_read : q.flags;

    if (reset_event) begin
      d.flags       = FLAGS_RESET;
      d.after_reset = 1'b1;
    // first event clears even if suppressed
    end else if (q.after_reset && (|events)) begin
      d.flags       = REG_RESET;
      d.after_reset = 1'b0;
    end else begin
      d.flags = (base & ~clr) | events;
      if (rd_clear) begin
        d.after_reset = 1'b0;
      end
    end

    if (buffer_lock_enable && host_run_mode && (events[F_END_A] | events[F_END_B])) begin
      d.lock_hold = 1'b1;
    end else if (q.buf_done) begin
      d.lock_hold = 1'b0;
    end

    active = q.after_reset | (|(q.flags & ~q.suppress)) | q.lock_hold;
    level = q.mode_one[IRQ_POL_BIT] ? active : ~active;
    d.irq_pin      = q.mode_one[SEL_IRQ_BIT] ? rx_data_strobe : level;
    d.clk_data_pin = q.mode_one[SEL_CLK_BIT] ? rx_data : divided_clock_out;
    d.run_pin      = q.mode_one[SEL_RUN_BIT] ? rx_data : rx_running;
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  assign link.miso         = q.miso;
  assign link.miso_oe      = q.miso_oe;
  assign link.irq_pin      = q.irq_pin;
  assign link.clk_data_pin = q.clk_data_pin;
  assign link.run_pin      = q.run_pin;
  assign buf_read_done     = q.buf_done;
endmodule : spih_device

// ---- spih_host.sv ----
// spih_host: serial master that issues one write, read or buffer read per command.
// assumes the device samples pins through two flops; half period covers that lag.
`timescale 1ns/100ps
module spih_host
  import spih_pkg::*;
#(
  parameter int BUF_W = BUF_BITS_DEF,
  parameter int HALF  = HOST_HALF_DEF
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  spih_if.host                  link,
  input  wire logic             cmd_valid,
  output logic                  cmd_ready,
  input  wire spih_op_e         cmd_op,
  input  wire logic [7:0]       cmd_addr,
  input  wire logic [7:0]       cmd_wdata,
  output logic                  rsp_valid,
  output logic [7:0]            rsp_data,
  output logic [BUF_W-1:0]      rsp_buf,
  output logic [7:0]            rsp_status
);
  localparam int SW = BUF_W + 2 * BYTE_BITS;
  localparam int CW = $clog2(SW + 1);
  localparam int HW = $clog2(HALF + 1);

  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW  = 3'b001,
    H_HIGH = 3'b010,
    H_END  = 3'b011,
    H_GAP  = 3'b100
  } spih_hst_e;

  typedef struct packed {
    spih_hst_e     st;
    logic [HW-1:0] ph;
    logic [CW-1:0] bits;
    logic [CW-1:0] total;
    logic [SW-1:0] sh;
    logic          cs_n;
    logic          sck;
    logic          mosi;
    logic          rsp_valid;
    logic [7:0]    rsp_data;
    logic [BUF_W-1:0] rsp_buf;
    logic [7:0]    rsp_status;
  } spih_hst_s;

  localparam spih_hst_s HST_RST = '{st: H_IDLE, cs_n: 1'b1, default: '0};

  logic miso_s;

  spih_sync #(
    .W   (1),
    .RST (HOST_MISO_IDLE)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .din   (link.miso),
    .dout  (miso_s)
  );

  spih_hst_s q;
  spih_hst_s d;

  always_comb begin
    logic half_end;
    half_end    = (q.ph == HW'(HALF - 1));
    d           = q;
    d.rsp_valid = 1'b0;
    d.ph        = half_end ? '0 : q.ph + HW'(1);
    unique case (q.st)
      H_IDLE: begin
        d.ph = '0;
        if (cmd_valid) begin
          d.cs_n = 1'b0;
          d.bits = '0;
          d.sh   = '0;
          d.st   = H_LOW;
          unique case (cmd_op)
            OP_WRITE: begin
              d.sh[SW-1 -: 3*BYTE_BITS] = {INS_WRITE, cmd_addr, cmd_wdata};
              d.total = CW'(3 * BYTE_BITS);
            end
            OP_READ: begin
              d.sh[SW-1 -: 2*BYTE_BITS] = {INS_READ, cmd_addr};
              d.total = CW'(3 * BYTE_BITS);
            end
            // instruction only, then bits and status
            default: begin
              d.sh[SW-1 -: BYTE_BITS] = INS_BUF_READ;
              d.total = CW'(SW);
            end
          endcase
          d.mosi = d.sh[SW-1];
        end
      end
      H_LOW: if (half_end) begin
        d.sck = 1'b1;
        d.sh  = {q.sh[SW-2:0], miso_s};
        d.st  = H_HIGH;
      end
      H_HIGH: if (half_end) begin
        d.sck = 1'b0;
        if (q.bits == q.total - CW'(1)) begin
          d.st = H_END;
        end else begin
          d.bits = q.bits + CW'(1);
          d.mosi = q.sh[SW-1];
          d.st   = H_LOW;
        end
      end
      H_END: if (half_end) begin
        d.cs_n       = 1'b1;
        d.mosi       = 1'b0;
        d.st         = H_GAP;
        d.rsp_data   = q.sh[BYTE_BITS-1:0];
        d.rsp_status = q.sh[BYTE_BITS-1:0];
        d.rsp_buf    = q.sh[SW-BYTE_BITS-1:BYTE_BITS];
      end
      H_GAP: if (half_end) begin
        d.rsp_valid = 1'b1;
        d.st        = H_IDLE;
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= HST_RST;
    end else begin
      q <= d;
    end
  end

  assign cmd_ready          = (q.st == H_IDLE);
  assign link.chip_select_n = q.cs_n;
  assign link.sck           = q.sck;
  assign link.mosi          = q.mosi;
  assign rsp_valid          = q.rsp_valid;
  assign rsp_data           = q.rsp_data;
  assign rsp_buf            = q.rsp_buf;
  assign rsp_status         = q.rsp_status;
endmodule : spih_host

// ---- spih_checker.sv ----
// spih_checker: wire-level properties of the link between host and device.
// assumes one clk domain and the host default half period of 8 clk.
`timescale 1ns/100ps
module spih_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chip_select_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic irq_pin,
  input wire logic clk_data_pin,
  input wire logic run_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // rising edges per selection, modulo one byte
  // ---------------------------------------------------------------
  logic       sck_q;
  logic [2:0] rise_cnt_q;
  logic [2:0] rise_cnt_d;
  always_comb begin
    rise_cnt_d = rise_cnt_q;
    if (chip_select_n) rise_cnt_d = 3'h0;
    else if (sck && !sck_q) rise_cnt_d = rise_cnt_q + 3'h1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck_q      <= 1'b0;
      rise_cnt_q <= 3'h0;
    end else begin
      sck_q      <= sck;
      rise_cnt_q <= rise_cnt_d;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sck_in_frame_a: assert property ($rose(sck) |-> !chip_select_n)
    else $error("serial clock rose while deselected");
  select_lead_a: assert property ($fell(chip_select_n) |-> ##[6:10] $rose(sck))
    else $error("no first clock edge after select");
  select_trail_a: assert property ($rose(chip_select_n) |-> !$past(sck, 1) && !$past(sck, 6))
    else $error("deselect too close to clock");
  mosi_hold_a: assert property ((sck && $past(sck)) |-> $stable(mosi))
    else $error("mosi moved while clock high");
  sck_high_a: assert property ($rose(sck) |-> sck [*8] ##1 !sck)
    else $error("clock high phase not eight cycles");
  miso_fall_a: assert property ((miso_oe && $past(miso_oe) && $changed(miso)) |->
                                $past(sck, 4) && !$past(sck, 3))
    else $error("miso changed away from a falling clock");
  oe_lag_a: assert property (miso_oe == !$past(chip_select_n, 3))
    else $error("miso enable does not follow select");
  frame_whole_a: assert property ($rose(chip_select_n) |-> rise_cnt_q == 3'h0)
    else $error("selection ended inside a byte");

  cover property ($rose(chip_select_n));
  cover property ($fell(irq_pin));
  cover property (miso_oe && $rose(miso));
  cover property ($changed(clk_data_pin));
  cover property ($changed(run_pin));
endmodule : spih_checker

// ---- spih_tb.sv ----
// testbench: host and device joined by the link; both user sides driven here.
// assumes default host half period and a 32 bit buffer.
`timescale 1ns/100ps
module testbench;
  import spih_pkg::*;
  typedef struct {logic [1:0] k; logic [7:0] d; logic [31:0] b; logic [7:0] s;} spih_exp_s;
  logic         clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         cmd_valid = 1'b0;
  spih_op_e     cmd_op = OP_READ;
  logic [7:0]   cmd_addr = 8'h00;
  logic [7:0]   cmd_wdata = 8'h00;
  logic [7:0]   events = 8'h00;
  logic         rst_ev = 1'b0;
  logic         lock_en = 1'b0;
  logic         run_mode = 1'b0;
  logic [31:0]  bb = 32'h0000_0000;
  logic [5:0]   cnt = 6'h00;
  logic         ovf = 1'b0;
  logic         div_clk = 1'b0;
  logic         rx_data = 1'b0;
  logic         rx_stb = 1'b0;
  logic         rx_run = 1'b0;
  logic         cmd_ready, rsp_valid, buf_done;
  logic [7:0]   rsp_data, rsp_status, a, d;
  logic [31:0]  rsp_buf;
  spih_exp_s    exp_q[$];
  spih_exp_s    mon_e;
  int           tests_run = 0;
  int           n_mismatch = 0;
  int           n_buf = 0;

  always #25 clk = ~clk;

  spih_if spih_if_inst ();
  spih_host spih_host_inst (.clk(clk), .rst_n(rst_n), .link(spih_if_inst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_buf(rsp_buf), .rsp_status(rsp_status));
  spih_device spih_device_inst (.clk(clk), .rst_n(rst_n), .link(spih_if_inst), .events(events),
    .reset_event(rst_ev), .buffer_lock_enable(lock_en), .host_run_mode(run_mode), .buf_bits(bb),
    .buf_count(cnt), .buf_overflow(ovf), .divided_clock_out(div_clk), .rx_data(rx_data),
    .rx_data_strobe(rx_stb), .rx_running(rx_run), .buf_read_done(buf_done));
  spih_checker spih_checker_inst (.clk(clk), .rst_n(rst_n), .chip_select_n(spih_if_inst.chip_select_n),
    .sck(spih_if_inst.sck), .mosi(spih_if_inst.mosi), .miso(spih_if_inst.miso),
    .miso_oe(spih_if_inst.miso_oe), .irq_pin(spih_if_inst.irq_pin),
    .clk_data_pin(spih_if_inst.clk_data_pin), .run_pin(spih_if_inst.run_pin));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // one command at a time; waits for its response before returning
  task automatic xfer(input spih_op_e op, input logic [7:0] ad, input logic [7:0] wd, input spih_exp_s e);
    int n;
    exp_q.push_back(e);
    @(posedge clk);
    #1;
    chk(cmd_ready, 1'b1, "host not ready");
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 3000) chk(0, 1, "response timeout");
  endtask : xfer

  task automatic rd(input logic [7:0] ad, input logic [7:0] ed);
    xfer(OP_READ, ad, 8'h00, '{2'd1, ed, '0, 8'h00});
  endtask : rd

  task automatic wr(input logic [7:0] ad, input logic [7:0] wd);
    xfer(OP_WRITE, ad, wd, '{2'd0, 8'h00, '0, 8'h00});
  endtask : wr

  task automatic pulse(input logic [7:0] ev, input logic re);
    @(posedge clk);
    #1;
    events = ev;
    rst_ev = re;
    @(posedge clk);
    #1;
    events = 8'h00;
    rst_ev = 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse

  // response watcher takes the oldest note
  always @(posedge clk) begin
    if (buf_done === 1'b1) n_buf++;
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk(0, 1, "response without request");
      else begin
        mon_e = exp_q.pop_front();
        if (mon_e.k == 2'd1) chk(rsp_data, mon_e.d, "read data");
        if (mon_e.k == 2'd2) chk(rsp_buf, mon_e.b, "buffer bits");
        if (mon_e.k == 2'd2) chk(rsp_status & 8'hBF, mon_e.s, "buffer status");
      end
    end
  end

  initial begin
    repeat (80000) @(posedge clk);
    chk(0, 1, "watchdog expired");
    tally_and_finish();
  end

  initial begin
    void'($urandom(67));
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk(spih_if_inst.irq_pin, 0, "irq after reset");
    wr(ADDR_SUPPRESS, 8'hFF);
    pulse(8'h04, 1'b0);
    chk(spih_if_inst.irq_pin, 1, "first event release");
    rd(ADDR_FLAGS, 8'h00);
    pulse(8'h00, 1'b1);
    chk(spih_if_inst.irq_pin, 0, "reset indication unmasked");
    rd(ADDR_FLAGS, FLAGS_RESET);
    chk(spih_if_inst.irq_pin, 1, "released by read");
    rd(ADDR_FLAGS, 8'h00);
    $display("test reset events done");
    // unmapped range, so the write stores nothing but the traces
    a = 8'h60 | 8'($urandom & 32'h1F);
    d = 8'($urandom);
    wr(a, d);
    rd(ADDR_TRACE_ADDR, a);
    rd(ADDR_TRACE_DATA, d);
    rd(a, 8'h00);
    rd(ADDR_SUPPRESS, 8'h00);
    $display("test traces done");
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_SUPPRESS, 8'h01 << i);
      pulse(8'h01 << i, 1'b0);
      chk(spih_if_inst.irq_pin, 1, "suppressed event");
      rd(ADDR_FLAGS, 8'h01 << i);
      wr(ADDR_SUPPRESS, ~(8'h01 << i));
      pulse(8'h01 << i, 1'b0);
      chk(spih_if_inst.irq_pin, 0, "active event");
      rd(ADDR_FLAGS, 8'h01 << i);
      chk(spih_if_inst.irq_pin, 1, "cleared by read");
    end
    $display("test mask done");
    pulse(8'hEE, 1'b0);
    pulse(8'h01, 1'b0);
    rd(ADDR_FLAGS, 8'hCD);
    pulse(8'hEE, 1'b0);
    pulse(8'h20, 1'b0);
    rd(ADDR_FLAGS, 8'h20);
    $display("test side clears done");
    wr(ADDR_SUPPRESS, 8'h00);
    wr(ADDR_MODE_ONE, 8'h20);
    chk(spih_if_inst.irq_pin, 0, "inverted idle");
    pulse(8'h10, 1'b0);
    chk(spih_if_inst.irq_pin, 1, "inverted active");
    rd(ADDR_FLAGS, 8'h10);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_MODE_ONE, {5'h00, i[2:0]});
      {div_clk, rx_data, rx_stb, rx_run} = 4'($urandom);
      repeat (4) @(posedge clk);
      #1;
      chk(spih_if_inst.clk_data_pin, i[2] ? rx_data : div_clk, "clock pin");
      chk(spih_if_inst.run_pin, i[0] ? rx_data : rx_run, "run pin");
      chk(spih_if_inst.irq_pin, i[1] ? rx_stb : 1'b1, "irq pin");
    end
    wr(ADDR_MODE_ONE, 8'h00);
    $display("test routing done");
    lock_en = 1'b1;
    run_mode = 1'b1;
    pulse(8'h08, 1'b0);
    rd(ADDR_FLAGS, 8'h08);
    chk(spih_if_inst.irq_pin, 0, "held by lock");
    bb = $urandom;
    cnt = 6'($urandom);
    ovf = 1'($urandom);
    xfer(OP_BUF, 8'h00, 8'h00, '{2'd2, 8'h00, bb, {ovf, 1'b0, cnt}});
    chk(n_buf, 1, "buffer read end");
    chk(spih_if_inst.irq_pin, 1, "lock released");
    $display("test buffer done");
    // event lands while the flags byte is shifting out
    fork
      rd(ADDR_FLAGS, 8'h00);
      begin
        repeat (300) @(posedge clk);
        pulse(8'h10, 1'b0);
      end
    join
    rd(ADDR_FLAGS, 8'h10);
    $display("test late event done");
    tally_and_finish();
  end
endmodule : testbench
